// File: inc/rtc_pkg.sv
// Purpose: Shared constants and types for the real-time control input evaluator
// Assumes: One serial bit per aclk edge, MSB first within each field
// Notes: Field positions count bits after the start bit
package rtc_pkg;
    // Register byte addresses
    localparam logic [3:0] RTC_OFS_CTRL = 4'h0;
    localparam logic [3:0] RTC_OFS_OWN_INC = 4'h4;
    localparam logic [3:0] RTC_OFS_STATUS = 4'h8;
    localparam logic [3:0] RTC_OFS_RX_INC = 4'hC;
    // Control register field positions
    localparam int RTC_CTRL_ENABLE = 0;
    localparam int RTC_CTRL_PHASE_FROM = 1;
    localparam int RTC_CTRL_PHASE_SEL_LO = 2;
    localparam int RTC_CTRL_PHASE_SEL_HI = 3;
    localparam int RTC_CTRL_FIELD_FROM = 4;
    localparam int RTC_CTRL_OE_FROM = 5;
    localparam int RTC_CTRL_COL_GATE = 6;
    localparam int RTC_CTRL_FIELD_SEL = 7;
    localparam logic [7:0] RTC_CTRL_RESET = 8'h00;
    localparam logic [1:0] RTC_PHASE_SEL_INPUT = 2'h0;
    // Serial frame layout, AXI response codes and receiver states
    localparam int RTC_INC_W = 22;
    localparam logic [8:0] RTC_POS_LINE_LAST = 9'h015;
    localparam logic [8:0] RTC_POS_SC_FIRST = 9'h018;
    localparam logic [8:0] RTC_POS_SC_LAST = 9'h02D;
    localparam logic [8:0] RTC_POS_SEQ = 9'h033;
    localparam logic [8:0] RTC_POS_RESET = 9'h034;
    localparam logic [8:0] RTC_POS_FIELD = 9'h035;
    localparam logic [8:0] RTC_POS_OE = 9'h036;
    localparam logic [8:0] RTC_POS_COL = 9'h037;
    localparam logic [8:0] RTC_TAIL_50 = 9'h0E5;
    localparam logic [8:0] RTC_TAIL_60 = 9'h0E2;
    localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {RTC_IDLE, RTC_BODY, RTC_TAIL} rtc_state_t;
endpackage : rtc_pkg

// File: core/rtc_eval.sv
// Purpose: Evaluates the real-time control serial stream from a video decoder
// Assumes: Stream idles low; a high start bit opens each frame; bits sampled on aclk
// Notes: Control, own increment and received fields reached over AXI4-Lite
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module rtc_eval
    import rtc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic realtime_control_input,
    input wire logic internal_odd_even,
    output logic [RTC_INC_W-1:0] subcarrier_increment,
    output logic subcarrier_phase_reset,
    output logic field_rate_60,
    output logic odd_even,
    output logic line_invert,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        rtc_state_t state;
        logic [8:0] cnt;
        logic [RTC_INC_W-1:0] sc_shift;
        logic [RTC_INC_W-1:0] rx_inc;
        logic rx_seq;
        logic rx_reset;
        logic rx_field;
        logic rx_oe;
        logic rx_col;
        logic rx_valid;
        logic [7:0] ctrl;
        logic [RTC_INC_W-1:0] own_inc;
        logic [RTC_INC_W-1:0] sc_out;
        logic phase_pulse;
        logic field_out;
        logic oe_out;
        logic inv_out;
        logic aw_full;
        logic [3:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } rtc_regs_t;

    rtc_regs_t r;
    rtc_regs_t next_r;

    function automatic logic addr_mapped(input logic [3:0] a);
        addr_mapped = (a == RTC_OFS_CTRL) || (a == RTC_OFS_OWN_INC) ||
                      (a == RTC_OFS_STATUS) || (a == RTC_OFS_RX_INC);
    endfunction : addr_mapped

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] d,
                                                input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge_bytes = m;
    endfunction : merge_bytes

    logic enable;
    logic use_rx_inc;
    logic field_eff;
    logic [8:0] tail_len;
    logic frame_done;
    logic [31:0] merged;

    always_comb begin
        next_r = r;
        next_r.phase_pulse = 1'b0;
        frame_done = 1'b0;
        enable = r.ctrl[RTC_CTRL_ENABLE];
        // Subcarrier source choice
        use_rx_inc = enable && r.rx_valid &&
                     (!r.ctrl[RTC_CTRL_COL_GATE] || r.rx_col);
        field_eff = (enable && r.ctrl[RTC_CTRL_FIELD_FROM]) ? r.rx_field
                                                           : r.ctrl[RTC_CTRL_FIELD_SEL];
        tail_len = field_eff ? RTC_TAIL_60 : RTC_TAIL_50;
        merged = 32'h0000_0000;

        // Serial frame receiver
        unique case (r.state)
            RTC_IDLE: begin
                next_r.cnt = 9'h000;
                if (realtime_control_input) begin
                    next_r.state = RTC_BODY;
                end
            end
            RTC_BODY: begin
                next_r.cnt = r.cnt + 9'h001;
                // Line increment and reserved bits pass unused; short sources pad high bits
                if (r.cnt >= RTC_POS_SC_FIRST && r.cnt <= RTC_POS_SC_LAST) begin
                    next_r.sc_shift = {r.sc_shift[RTC_INC_W-2:0], realtime_control_input};
                end
                if (r.cnt == RTC_POS_SEQ) begin
                    next_r.rx_seq = realtime_control_input;
                end
                if (r.cnt == RTC_POS_RESET) begin
                    next_r.rx_reset = realtime_control_input;
                end
                if (r.cnt == RTC_POS_FIELD) begin
                    next_r.rx_field = realtime_control_input;
                end
                if (r.cnt == RTC_POS_OE) begin
                    next_r.rx_oe = realtime_control_input;
                end
                if (r.cnt == RTC_POS_COL) begin
                    next_r.rx_col = realtime_control_input;
                    next_r.rx_inc = r.sc_shift;
                    next_r.rx_valid = 1'b1;
                    next_r.state = RTC_TAIL;
                    next_r.cnt = 9'h001;
                    frame_done = 1'b1;
                end
            end
            RTC_TAIL: begin
                next_r.cnt = r.cnt + 9'h001;
                if (r.cnt >= tail_len) begin
                    next_r.state = RTC_IDLE;
                    next_r.cnt = 9'h000;
                end
            end
            // Unused state code falls back to idle
            default: begin
                next_r.state = RTC_IDLE;
                next_r.cnt = 9'h000;
            end
        endcase

        // Phase reset at most once per received line, when its reset bit is set
        if (frame_done && enable && r.ctrl[RTC_CTRL_PHASE_FROM] &&
            r.ctrl[RTC_CTRL_PHASE_SEL_HI:RTC_CTRL_PHASE_SEL_LO] == RTC_PHASE_SEL_INPUT &&
            r.rx_reset) begin
            next_r.phase_pulse = 1'b1;
        end

        next_r.sc_out = use_rx_inc ? r.rx_inc : r.own_inc;
        next_r.field_out = field_eff;
        next_r.oe_out = (enable && r.ctrl[RTC_CTRL_OE_FROM]) ? r.rx_oe : internal_odd_even;
        next_r.inv_out = enable && r.rx_seq;

        // AXI4-Lite write path
        if (s_axi_awvalid && !r.aw_full && !r.bvalid) begin
            next_r.aw_full = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_full && !r.bvalid) begin
            next_r.w_full = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.aw_full && r.w_full) begin
            next_r.aw_full = 1'b0;
            next_r.w_full = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = addr_mapped(r.aw_addr) ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
            if (r.aw_addr == RTC_OFS_CTRL) begin
                merged = merge_bytes({24'h000000, r.ctrl}, r.w_data, r.w_strb);
                next_r.ctrl = merged[7:0];
            end
            if (r.aw_addr == RTC_OFS_OWN_INC) begin
                merged = merge_bytes({10'h000, r.own_inc}, r.w_data, r.w_strb);
                next_r.own_inc = merged[RTC_INC_W-1:0];
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // AXI4-Lite read path
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = addr_mapped(s_axi_araddr) ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
            unique case (s_axi_araddr)
                RTC_OFS_CTRL: next_r.rdata = {24'h000000, r.ctrl};
                RTC_OFS_OWN_INC: next_r.rdata = {10'h000, r.own_inc};
                RTC_OFS_STATUS: next_r.rdata = {26'h0000000, r.rx_valid, r.rx_col, r.rx_oe,
                                                r.rx_field, r.rx_reset, r.rx_seq};
                RTC_OFS_RX_INC: next_r.rdata = {10'h000, r.rx_inc};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // Ready flags registered so every port comes from a flip-flop
        next_r.aw_rdy = !next_r.aw_full && !next_r.bvalid;
        next_r.w_rdy = !next_r.w_full && !next_r.bvalid;
        next_r.ar_rdy = !next_r.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.state <= RTC_IDLE;
            r.ctrl <= RTC_CTRL_RESET;
            // Channels ready out of reset
            r.aw_rdy <= 1'b1;
            r.w_rdy <= 1'b1;
            r.ar_rdy <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign subcarrier_increment = r.sc_out;
    assign subcarrier_phase_reset = r.phase_pulse;
    assign field_rate_60 = r.field_out;
    assign odd_even = r.oe_out;
    assign line_invert = r.inv_out;
    assign s_axi_awready = r.aw_rdy;
    assign s_axi_wready = r.w_rdy;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.ar_rdy;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_frame_end;
        r.state == RTC_BODY && r.cnt == RTC_POS_COL;
    endsequence

    sequence seq_phase_armed;
        r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_PHASE_FROM] && r.rx_reset &&
        r.ctrl[RTC_CTRL_PHASE_SEL_HI:RTC_CTRL_PHASE_SEL_LO] == RTC_PHASE_SEL_INPUT;
    endsequence

    sequence seq_one_pulse;
        subcarrier_phase_reset ##1 !subcarrier_phase_reset;
    endsequence

    // Output selection, phase pulse and frame length
    chk_rx_source: assert property (
        r.ctrl[RTC_CTRL_ENABLE] && r.rx_valid && !r.ctrl[RTC_CTRL_COL_GATE] |=>
        subcarrier_increment == $past(r.rx_inc))
        else $error("received increment not used");
    chk_colour_gate: assert property (
        r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_COL_GATE] && !r.rx_col |=>
        subcarrier_increment == $past(r.own_inc))
        else $error("own increment not used without colour");
    chk_disabled_own: assert property (
        !r.ctrl[RTC_CTRL_ENABLE] |=> subcarrier_increment == $past(r.own_inc) && !line_invert)
        else $error("received field used while disabled");
    chk_phase_pulse: assert property (
        seq_frame_end ##0 seq_phase_armed |=> seq_one_pulse)
        else $error("phase reset pulse wrong");
    chk_phase_quiet: assert property (
        subcarrier_phase_reset |-> $past(r.ctrl[RTC_CTRL_ENABLE]) && $past(r.ctrl[RTC_CTRL_PHASE_FROM]))
        else $error("phase reset while not enabled");
    chk_field_choice: assert property (
        r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_FIELD_FROM] |=> field_rate_60 == $past(r.rx_field))
        else $error("field rate not taken from input");
    chk_odd_even: assert property (
        r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_OE_FROM] |=> odd_even == $past(r.rx_oe))
        else $error("odd even not taken from input");
    chk_tail_len: assert property (
        r.state == RTC_TAIL && r.cnt == RTC_TAIL_50 && !field_rate_60 && !r.field_out |=> r.state == RTC_IDLE)
        else $error("50 Hz tail length wrong");
    chk_body_len: assert property (
        $rose(r.state == RTC_BODY) |-> (r.state == RTC_BODY) [*8])
        else $error("frame body ended early");
    chk_phase_line: assert property (
        subcarrier_phase_reset |-> $past(frame_done) && $past(r.rx_reset))
        else $error("phase reset outside a received line");
    chk_line_invert: assert property (
        r.ctrl[RTC_CTRL_ENABLE] |=> line_invert == $past(r.rx_seq))
        else $error("sequence bit not passed to line invert");
    chk_field_own: assert property (
        !(r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_FIELD_FROM]) |=>
        field_rate_60 == $past(r.ctrl[RTC_CTRL_FIELD_SEL]))
        else $error("programmed field rate not used");
    chk_odd_even_own: assert property (
        !(r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_OE_FROM]) |=> odd_even == $past(internal_odd_even))
        else $error("internal odd even not used");
    chk_colour_take: assert property (
        r.ctrl[RTC_CTRL_ENABLE] && r.ctrl[RTC_CTRL_COL_GATE] && r.rx_col && r.rx_valid |=>
        subcarrier_increment == $past(r.rx_inc))
        else $error("received increment not used with colour");
    chk_own_first: assert property (
        !r.rx_valid |=> subcarrier_increment == $past(r.own_inc))
        else $error("increment used before any frame");

    // Receiver framing
    chk_line_pll_unused: assert property (
        r.state == RTC_BODY && r.cnt < RTC_POS_SC_FIRST |=> r.sc_shift == $past(r.sc_shift))
        else $error("line increment reached the subcarrier field");
    chk_rx_latch: assert property (
        seq_frame_end |=> r.rx_valid && r.rx_inc == $past(r.sc_shift))
        else $error("received increment not latched");
    chk_body_hold: assert property (
        r.state == RTC_BODY && r.cnt < RTC_POS_COL |=> r.state == RTC_BODY)
        else $error("frame body ended before the colour bit");
    chk_tail_hold: assert property (
        r.state == RTC_TAIL && r.cnt < RTC_TAIL_60 |=> r.state == RTC_TAIL)
        else $error("reserved tail ended early");
    chk_tail_short: assert property (
        r.state == RTC_TAIL && r.cnt == RTC_TAIL_60 && field_rate_60 |=> r.state == RTC_IDLE)
        else $error("60 Hz tail length wrong");

endmodule : rtc_eval

// File: bench/rtc_decoder_model.sv
// Purpose: Behavioural video decoder that sends real-time control frames
// Assumes: One bit per aclk edge, driven just after the rising edge; line idles low
// Notes: Ignored and reserved positions carry non-zero patterns on purpose
`timescale 1ns/100ps
module rtc_decoder_model (
    input wire logic aclk,
    output logic realtime_control_input
);
    initial realtime_control_input = 1'b0;

    task automatic send_frame(input logic [21:0] sc, input logic seq, input logic rst, input logic fr,
                              input logic oe, input logic col, input int tail);
        logic [55:0] f;
        f = {22'h2AAAAA, 2'h2, sc, 5'h15, seq, rst, fr, oe, col};
        @(posedge aclk) realtime_control_input <= 1'b1;
        for (int k = 55; k >= 0; k--) begin
            @(posedge aclk) realtime_control_input <= f[k];
        end
        // Tail toggles and ends low, so a miscounted tail shows up as a false start
        for (int i = tail - 1; i >= 0; i--) begin
            @(posedge aclk) realtime_control_input <= i[0];
        end
    endtask : send_frame
endmodule : rtc_decoder_model

// File: bench/rtc_eval_tb.sv
// Purpose: Self-checking bench for the real-time control input evaluator
// Assumes: Register access over AXI4-Lite; decoder model drives the serial line
// Notes: Frames after the first are sent in back-to-back pairs, so tail length errors misalign later frames
`timescale 1ns/100ps
module rtc_eval_tb;
    import rtc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic realtime_control_input;
    logic internal_odd_even = 1'b0;
    logic [RTC_INC_W-1:0] subcarrier_increment;
    logic subcarrier_phase_reset, field_rate_60, odd_even, line_invert;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_pulse = 0;

    rtc_eval u_rtc_eval (.aclk, .aresetn, .realtime_control_input, .internal_odd_even, .subcarrier_increment,
        .subcarrier_phase_reset, .field_rate_60, .odd_even, .line_invert, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    rtc_decoder_model u_rtc_decoder_model (.aclk(aclk), .realtime_control_input(realtime_control_input));

    always #2.5 aclk = ~aclk;

    always @(posedge aclk) begin
        if (subcarrier_phase_reset === 1'b1) n_pulse++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                chk(32'(s_axi_bresp), 32'(er));
                return;
            end
        end
        chk(32'h0, 32'h1);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, ed);
                chk(32'(s_axi_rresp), 32'(er));
                return;
            end
        end
        chk(32'h0, 32'h1);
    endtask : axi_rd

    task automatic chk_out(input logic [21:0] inc, input logic fr, input logic oe, input logic li, input int np);
        @(negedge aclk);
        chk(32'(subcarrier_increment), 32'(inc));
        chk(32'(field_rate_60), 32'(fr));
        chk(32'(odd_even), 32'(oe));
        chk(32'(line_invert), 32'(li));
        chk(32'(n_pulse), 32'(np));
    endtask : chk_out

    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #60000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(RTC_OFS_CTRL, 32'h0, RTC_RESP_OKAY);
        axi_rd(4'h6, 32'h0, RTC_RESP_SLVERR);
        axi_wr(4'h2, 32'h000000FF, RTC_RESP_SLVERR);
        axi_rd(RTC_OFS_CTRL, 32'h0, RTC_RESP_OKAY);
        axi_wr(RTC_OFS_OWN_INC, 32'hFFF12345, RTC_RESP_OKAY);
        axi_rd(RTC_OFS_OWN_INC, 32'h00312345, RTC_RESP_OKAY);
        // Disabled: programmed 60 Hz select, own flags
        internal_odd_even <= 1'b1;
        axi_wr(RTC_OFS_CTRL, 32'h00000080, RTC_RESP_OKAY);
        u_rtc_decoder_model.send_frame(22'h0ABCDE, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 226);
        chk_out(22'h312345, 1'b1, 1'b1, 1'b0, 0);
        // Enabled, phase select 00, no colour gating; second frame from a short source
        axi_wr(RTC_OFS_CTRL, 32'h00000033, RTC_RESP_OKAY);
        u_rtc_decoder_model.send_frame(22'h155555, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 229);
        u_rtc_decoder_model.send_frame(22'h004ABC, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 229);
        chk_out(22'h004ABC, 1'b0, 1'b0, 1'b1, 1);
        axi_rd(RTC_OFS_RX_INC, 32'h00004ABC, RTC_RESP_OKAY);
        axi_rd(RTC_OFS_STATUS, 32'h00000023, RTC_RESP_OKAY);
        // Colour gating on
        axi_wr(RTC_OFS_CTRL, 32'h00000073, RTC_RESP_OKAY);
        u_rtc_decoder_model.send_frame(22'h2F0F0F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 229);
        chk_out(22'h312345, 1'b0, 1'b0, 1'b1, 1);
        u_rtc_decoder_model.send_frame(22'h2F0F0F, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 229);
        chk_out(22'h2F0F0F, 1'b0, 1'b1, 1'b0, 1);
        // Phase select 01 blocks the reset; received 60 Hz shortens the tail
        axi_wr(RTC_OFS_CTRL, 32'h00000037, RTC_RESP_OKAY);
        u_rtc_decoder_model.send_frame(22'h3C3C3C, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 226);
        u_rtc_decoder_model.send_frame(22'h3C3C3C, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 226);
        chk_out(22'h3C3C3C, 1'b1, 1'b0, 1'b1, 1);
        // Byte strobes: only the low byte of the own increment changes
        axi_rd(RTC_OFS_CTRL, 32'h00000037, RTC_RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axi_wr(RTC_OFS_OWN_INC, 32'hFFFFFFAA, RTC_RESP_OKAY);
        axi_rd(RTC_OFS_OWN_INC, 32'h003123AA, RTC_RESP_OKAY);
        wrap_up;
    end
endmodule : rtc_eval_tb
